// ### common/dco_pkg.sv
// constants shared by the oscillator period control and its dither selector
package dco_pkg;

  // code widths
  localparam int CODE_W   = 12;
  localparam int STG_W    = 8;
  localparam int DIV_W    = 4;
  localparam int DITHER_W = 5;
  localparam int UPPER_W  = 3;
  localparam int LEN_W    = 6;
  localparam int DCNT_W   = 10;
  localparam int MULT_W   = 7;
  localparam int FREQ_W   = 26;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // combined divider/stage code limits
  localparam logic [CODE_W-1:0] CODE_MIN   = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MAX   = 12'h9ff;
  localparam logic [CODE_W-1:0] CODE_ONE   = 12'h001;
  localparam logic [CODE_W-1:0] CODE_RST   = 12'h400;
  localparam logic [DIV_W-1:0]  DIV_MAX    = 4'h9;
  localparam logic [DIV_W-1:0]  DIV_NONE   = 4'h0;
  localparam logic [STG_W-1:0]  STG_ALL1   = 8'hff;
  localparam logic [STG_W-1:0]  STG_ALL0   = 8'h00;

  // ring lengths in stage delays
  localparam logic [LEN_W-1:0]   RING_BASE      = 6'h11;
  localparam logic [LEN_W-1:0]   RING_STEP      = 6'h02;
  localparam logic [LEN_W-1:0]   RING_LONG_111  = 6'h22;
  localparam logic [LEN_W-1:0]   RING_MAX       = 6'h22;
  localparam logic [LEN_W-1:0]   LEN_ONE        = 6'h01;
  localparam logic [UPPER_W-1:0] UPPER_MAX      = 3'h7;
  localparam logic [DITHER_W-1:0] DITHER_NONE   = 5'h00;
  localparam logic [DITHER_W-1:0] FRAME_FIRST   = 5'h00;
  localparam logic [DITHER_W-1:0] FRAME_LAST    = 5'h1f;
  localparam logic [DITHER_W-1:0] FRAME_ONE     = 5'h01;
  localparam logic [DCNT_W-1:0]   DCNT_ONE      = 10'h001;
  localparam logic [DCNT_W-1:0]   DCNT_ZERO     = 10'h000;

  // base reference clock, 307.2 kHz
  localparam logic [FREQ_W-1:0] BASE_REF_HZ = 26'h004_b000;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MULT   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CODE   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_TARGET = 4'hc;

  // control register fields
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int CTRL_FAULT_BIT  = 1;
  localparam int CTRL_STABLE_BIT = 2;

  // reset values; multiply factor default is arbitrary
  localparam logic [MULT_W-1:0] MULT_RST  = 7'h15;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : dco_pkg

// ### hw/ring_length_select.sv
// dither frame counter and ring length choice per ring cycle
`timescale 1ns/100ps
module ring_length_select (
  input  wire logic                         clk_in,
  input  wire logic                         resetn_in,
  input  wire logic                         ring_end_in,
  input  wire logic [dco_pkg::STG_W-1:0]    stage_code_in,
  output logic      [dco_pkg::LEN_W-1:0]    ring_len_out,
  output logic      [dco_pkg::LEN_W-1:0]    nominal_len_out,
  output logic                              long_sel_out
);
  import dco_pkg::*;

  logic [DITHER_W-1:0] frame_q;
  logic [UPPER_W-1:0]  upper;
  logic [DITHER_W-1:0] fine;

  assign upper = stage_code_in[STG_W-1:DITHER_W];
  assign fine  = stage_code_in[DITHER_W-1:0];

  // modulo-32 count of ring cycles
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      frame_q <= FRAME_FIRST;
    end else if (ring_end_in) begin
      frame_q <= frame_q + FRAME_ONE;
    end
  end

  always_comb begin
    nominal_len_out = RING_BASE + RING_STEP * LEN_W'(upper);
    long_sel_out    = (frame_q < fine);
    if (!long_sel_out) begin
      ring_len_out = nominal_len_out;
    end else if (upper == UPPER_MAX) begin
      ring_len_out = RING_LONG_111;
    end else begin
      ring_len_out = nominal_len_out + RING_STEP;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_frame_wrap: assert property (
    (ring_end_in && frame_q == FRAME_LAST) |=> frame_q == FRAME_FIRST)
    else $error("dither frame did not wrap after 32 ring cycles");
  chk_dither_first: assert property (
    (frame_q == FRAME_FIRST && fine != DITHER_NONE)
      |-> ring_len_out != nominal_len_out)
    else $error("nonzero fine code gave no long cycle at frame start");
  chk_no_dither: assert property (
    (fine == DITHER_NONE) |-> (!long_sel_out && ring_len_out == nominal_len_out))
    else $error("dither active with zero fine code");

endmodule : ring_length_select

// ### hw/dco_period_control.sv
// digital oscillator period control with register port and monitor gating
//
// Functional notes
// - period set only by stage and divider codes
// - divider code saturates at nine, divide 512
// - divider zero undivided, each step doubles period
// - divider moves only on stage carry or borrow, or on a code register write
// - upper stage bits give 17 to 31 delays
// - fine value k gives k long cycles per 32
// - fine value zero gives nominal length always
// - upper 111 long point is 34 delays
// - target frequency is multiplier times base reference
// - monitor enable refused until clock stable
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module dco_period_control (
  input  wire logic                          clk_in,
  input  wire logic                          resetn_in,
  input  wire logic [dco_pkg::ADDR_W-1:0]    addr_in,
  input  wire logic [dco_pkg::DATA_W-1:0]    wr_data_in,
  input  wire logic                          wr_en_in,
  input  wire logic                          rd_en_in,
  output logic      [dco_pkg::DATA_W-1:0]    rd_data_out,
  input  wire logic                          loop_filter_up_in,
  input  wire logic                          loop_filter_down_in,
  input  wire logic                          internal_clk_stable_in,
  input  wire logic                          monitor_fault_in,
  output logic      [dco_pkg::DIV_W-1:0]     osc_divider_code_out,
  output logic      [dco_pkg::STG_W-1:0]     osc_stage_code_out,
  output logic      [dco_pkg::LEN_W-1:0]     ring_len_out,
  output logic                               internal_clk_tick_out,
  output logic                               monitor_enable_out,
  output logic                               monitor_fault_flag_out,
  output logic      [dco_pkg::MULT_W-1:0]    multiply_factor_out,
  output logic      [dco_pkg::FREQ_W-1:0]    freq_target_out
);
  import dco_pkg::*;

  logic [CODE_W-1:0] code_q;
  logic [CODE_W-1:0] code_d;
  logic [DIV_W-1:0]  eff_div;
  logic [LEN_W-1:0]  delay_q;
  logic [LEN_W-1:0]  ring_len_q;
  logic [LEN_W-1:0]  sel_len;
  logic [LEN_W-1:0]  nominal_len;
  logic              sel_long;
  logic              ring_end;
  logic [DCNT_W-1:0] div_cnt_q;
  logic [DCNT_W-1:0] div_limit;
  logic              tick_q;
  logic [DIV_W-1:0]  div_out_q;
  logic              mon_en_q;
  logic              fault_q;
  logic              armed_q;
  logic [MULT_W-1:0] mult_q;
  logic [FREQ_W-1:0] freq_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              ctrl_wr;
  logic              mult_wr;
  logic              code_wr;
  logic              ctrl_rd;
  logic              fault_set;
  logic              fault_clr;

  assign ctrl_wr = wr_en_in && (addr_in == ADDR_CTRL);
  assign mult_wr = wr_en_in && (addr_in == ADDR_MULT);
  assign code_wr = wr_en_in && (addr_in == ADDR_CODE);
  assign ctrl_rd = rd_en_in && (addr_in == ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // combined divider/stage code

  // up and down together cancel; a software load wins over the filter
  always_comb begin
    code_d = code_q;
    if (code_wr) begin
      code_d = wr_data_in[CODE_W-1:0];
    end else if (loop_filter_up_in && !loop_filter_down_in) begin
      if (code_q < CODE_MAX) begin
        code_d = code_q + CODE_ONE;
      end
    end else if (loop_filter_down_in && !loop_filter_up_in) begin
      if (code_q != CODE_MIN) begin
        code_d = code_q - CODE_ONE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      code_q <= CODE_RST;
    end else begin
      code_q <= code_d;
    end
  end

  // codes above nine act as nine
  assign eff_div = (code_q[CODE_W-1:STG_W] > DIV_MAX) ? DIV_MAX
                                                      : code_q[CODE_W-1:STG_W];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      div_out_q <= DIV_NONE;
    end else begin
      div_out_q <= eff_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ring emulation: one stage delay per clock

  ring_length_select u_sel (
    .clk_in          (clk_in),
    .resetn_in       (resetn_in),
    .ring_end_in     (ring_end),
    .stage_code_in   (code_q[STG_W-1:0]),
    .ring_len_out    (sel_len),
    .nominal_len_out (nominal_len),
    .long_sel_out    (sel_long)
  );

  assign ring_end = (delay_q >= ring_len_q - LEN_ONE);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      delay_q    <= '0;
      ring_len_q <= RING_BASE;
    end else if (ring_end) begin
      delay_q    <= '0;
      ring_len_q <= sel_len;
    end else begin
      delay_q    <= delay_q + LEN_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-of-two divider on ring cycles

  assign div_limit = (DCNT_ONE << eff_div) - DCNT_ONE;

  // >= keeps the divider safe when the code drops mid-count
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      div_cnt_q <= DCNT_ZERO;
      tick_q    <= 1'b0;
    end else if (ring_end) begin
      if (div_cnt_q >= div_limit) begin
        div_cnt_q <= DCNT_ZERO;
        tick_q    <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + DCNT_ONE;
        tick_q    <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiply factor and target frequency

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mult_q <= MULT_RST;
    end else if (mult_wr) begin
      mult_q <= wr_data_in[MULT_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      freq_q <= '0;
    end else begin
      freq_q <= FREQ_W'(mult_q) * BASE_REF_HZ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock monitor enable and fault flag

  // enable only while stable, or keep it if already on
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mon_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      mon_en_q <= wr_data_in[CTRL_MON_EN_BIT]
                  && (mon_en_q || internal_clk_stable_in);
    end
  end

  assign fault_set = monitor_fault_in && mon_en_q;
  assign fault_clr = ctrl_wr && armed_q && !wr_data_in[CTRL_FAULT_BIT];

  // a read of the control register while the fault flag is set arms the clear; any control write disarms
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      armed_q <= 1'b0;
    end else if (ctrl_wr) begin
      armed_q <= 1'b0;
    end else if (ctrl_rd && fault_q) begin
      armed_q <= 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (fault_clr) begin
      fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data valid in the cycle after the strobe only

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_data_q <= DATA_ZERO;
    end else if (rd_en_in) begin
      rd_data_q <= DATA_ZERO;
      case (addr_in)
        ADDR_CTRL: begin
          rd_data_q[CTRL_MON_EN_BIT] <= mon_en_q;
          rd_data_q[CTRL_FAULT_BIT]  <= fault_q;
          rd_data_q[CTRL_STABLE_BIT] <= internal_clk_stable_in;
        end
        ADDR_MULT: begin
          rd_data_q[MULT_W-1:0] <= mult_q;
        end
        ADDR_CODE: begin
          rd_data_q[CODE_W-1:0] <= code_q;
        end
        ADDR_TARGET: begin
          rd_data_q[FREQ_W-1:0] <= freq_q;
        end
        default: begin
          rd_data_q <= DATA_ZERO;
        end
      endcase
    end else begin
      rd_data_q <= DATA_ZERO;
    end
  end

  assign rd_data_out            = rd_data_q;
  assign osc_divider_code_out   = div_out_q;
  assign osc_stage_code_out     = code_q[STG_W-1:0];
  assign ring_len_out           = ring_len_q;
  assign internal_clk_tick_out  = tick_q;
  assign monitor_enable_out     = mon_en_q;
  assign monitor_fault_flag_out = fault_q;
  assign multiply_factor_out    = mult_q;
  assign freq_target_out        = freq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_code_step: assert property (
    (loop_filter_up_in && !loop_filter_down_in && !code_wr && code_q < CODE_MAX)
      |=> code_q == $past(code_q) + CODE_ONE)
    else $error("code did not step up on filter increment");
  chk_code_floor: assert property (
    (loop_filter_down_in && !loop_filter_up_in && !code_wr && code_q == CODE_MIN)
      |=> code_q == CODE_MIN)
    else $error("code wrapped below minimum");
  chk_div_clamp: assert property (
    ##1 osc_divider_code_out <= DIV_MAX)
    else $error("divider output above saturation");
  chk_div_carry: assert property (
    (!code_wr && code_d[CODE_W-1:STG_W] != code_q[CODE_W-1:STG_W])
      |-> (code_q[STG_W-1:0] == STG_ALL1 || code_q[STG_W-1:0] == STG_ALL0))
    else $error("divider moved without stage carry or borrow");
  chk_tick_undiv: assert property (
    (ring_end && eff_div == DIV_NONE) |=> internal_clk_tick_out)
    else $error("undivided ring cycle gave no output tick");
  chk_ring_range: assert property (
    ring_len_q >= RING_BASE && ring_len_q <= RING_MAX)
    else $error("ring length out of range");
  chk_nominal_only: assert property (
    (ring_end && code_q[DITHER_W-1:0] == DITHER_NONE)
      |=> ring_len_q == $past(nominal_len))
    else $error("zero fine code did not give nominal length");
  chk_long_111: assert property (
    (ring_end && sel_long && code_q[STG_W-1:DITHER_W] == UPPER_MAX)
      |=> ring_len_q == RING_LONG_111)
    else $error("top stage long point is not 34 delays");
  chk_freq_target: assert property (
    mult_wr |=> ##1 freq_target_out == FREQ_W'($past(wr_data_in[MULT_W-1:0], 2))
                                     * BASE_REF_HZ)
    else $error("target frequency does not follow multiplier");
  chk_monitor_refuse: assert property (
    (ctrl_wr && !internal_clk_stable_in && !monitor_enable_out)
      |=> !monitor_enable_out)
    else $error("monitor enabled while clock unstable");
  chk_fault_set_wins: assert property (
    fault_set |=> monitor_fault_flag_out [*1])
    else $error("fault event lost");

  cov_undivided_tick: cover property (ring_end && eff_div == DIV_NONE ##1 tick_q);
  cov_code_at_max:    cover property (code_q == CODE_MAX && loop_filter_up_in);
  cov_fault_cleared:  cover property (fault_q ##1 fault_clr ##1 !fault_q);
  cov_monitor_on:     cover property (!mon_en_q ##1 mon_en_q);

endmodule : dco_period_control

// ### bench/dco_period_control_tb_top.sv
// self-checking bench for the oscillator period control
`timescale 1ns/100ps
module dco_period_control_tb_top;
  import dco_pkg::*;
  logic              clk_in;
  logic              resetn_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in;
  logic              wr_en_in;
  logic              rd_en_in;
  logic [DATA_W-1:0] rd_data_out;
  logic              loop_filter_up_in;
  logic              loop_filter_down_in;
  logic              internal_clk_stable_in;
  logic              monitor_fault_in;
  logic [DIV_W-1:0]  osc_divider_code_out;
  logic [STG_W-1:0]  osc_stage_code_out;
  logic [LEN_W-1:0]  ring_len_out;
  logic              internal_clk_tick_out;
  logic              monitor_enable_out;
  logic              monitor_fault_flag_out;
  logic [MULT_W-1:0] multiply_factor_out;
  logic [FREQ_W-1:0] freq_target_out;
  logic [31:0]       xs_q;
  int                err_count;
  int                check_count;

  dco_period_control DUT (.clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .loop_filter_up_in, .loop_filter_down_in, .internal_clk_stable_in,
    .monitor_fault_in, .osc_divider_code_out, .osc_stage_code_out, .ring_len_out,
    .internal_clk_tick_out, .monitor_enable_out, .monitor_fault_flag_out,
    .multiply_factor_out, .freq_target_out);

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    xs_q = xs_q ^ (xs_q << 13);
    xs_q = xs_q ^ (xs_q >> 17);
    xs_q = xs_q ^ (xs_q << 5);
    return xs_q;
  endfunction : xs

  // expected ring lengths for an upper stage code: nominal and long dither point
  function automatic int nom_len(input logic [2:0] u);
    return 17 + 2 * int'(u);
  endfunction : nom_len

  function automatic int long_len(input logic [2:0] u);
    return (u == 3'h7) ? 34 : nom_len(u) + 2;
  endfunction : long_len

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_cnt

  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask : bus_write

  task automatic read_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    @(negedge clk_in);
    check_val(rd_data_out, exp);
  endtask : read_check

  // clocks from one output tick to the next
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (internal_clk_tick_out !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      err_count++;
    end
  endtask : wait_tick

  // loop filter steps, f nonzero forces the up/down pair
  task automatic walk(input logic [11:0] start, input logic [1:0] f, input int cyc);
    logic [11:0] m;
    logic [31:0] r;
    bus_write(ADDR_CODE, {20'h0_0000, start});
    m = start;
    repeat (cyc) begin
      r = xs();
      loop_filter_up_in   <= (f != 2'b00) ? f[0] : r[0];
      loop_filter_down_in <= (f != 2'b00) ? f[1] : r[1];
      @(posedge clk_in);
      if (loop_filter_up_in && !loop_filter_down_in && m < CODE_MAX) m++;
      if (loop_filter_down_in && !loop_filter_up_in && m > CODE_MIN) m--;
    end
    loop_filter_up_in   <= 1'b0;
    loop_filter_down_in <= 1'b0;
    @(posedge clk_in);
    if (loop_filter_up_in && !loop_filter_down_in && m < CODE_MAX) m++;
    if (loop_filter_down_in && !loop_filter_up_in && m > CODE_MIN) m--;
    @(negedge clk_in);
    check_val(osc_stage_code_out, m[7:0]);
    @(negedge clk_in);
    check_val(osc_divider_code_out, m[11:8]);
    read_check(ADDR_CODE, {20'h0_0000, m});
  endtask : walk

  task automatic period(input logic [3:0] d, input logic [2:0] u);
    int n;
    bus_write(ADDR_CODE, {20'h0_0000, d, u, 5'h00});
    repeat (3) wait_tick(n);
    check_cnt(n, (1 << d) * nom_len(u));
    check_val(ring_len_out, nom_len(u));
  endtask : period

  task automatic dither(input logic [2:0] u, input logic [4:0] k);
    int n;
    int longs;
    int nom;
    int lng;
    bus_write(ADDR_CODE, {20'h0_0000, 4'h0, u, k});
    repeat (3) wait_tick(n);
    nom   = nom_len(u);
    lng   = long_len(u);
    longs = 0;
    repeat (32) begin
      wait_tick(n);
      if (n == lng) longs++;
      else check_cnt(n, nom);
    end
    check_cnt(longs, k);
  endtask : dither

  task automatic fault_pulse();
    @(posedge clk_in);
    monitor_fault_in <= 1'b1;
    @(posedge clk_in);
    monitor_fault_in <= 1'b0;
    @(negedge clk_in);
  endtask : fault_pulse

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [6:0]  n;
    xs_q = 32'h49e0_9347;
    err_count = 0;
    check_count = 0;
    {resetn_in, wr_en_in, rd_en_in, loop_filter_up_in, loop_filter_down_in} = 5'h00;
    {internal_clk_stable_in, monitor_fault_in} = 2'b00;
    addr_in = 4'h0;
    wr_data_in = 32'h0000_0000;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    read_check(ADDR_CTRL, 32'h0000_0000);
    read_check(ADDR_MULT, 32'h0000_0015);
    read_check(ADDR_CODE, 32'h0000_0400);
    read_check(ADDR_TARGET, 32'h0000_0015 * 32'h0004_b000);
    walk(12'h4ff, 2'b01, 1);
    walk(12'h500, 2'b10, 1);
    walk(12'h9fe, 2'b01, 4);
    walk(12'h001, 2'b10, 4);
    walk(12'h123, 2'b11, 3);
    repeat (3) begin
      r = xs();
      walk(r[11:0] % 12'ha00, 2'b00, 200);
    end
    bus_write(ADDR_CODE, 32'h0000_0c00);
    repeat (2) @(negedge clk_in);
    check_val(osc_divider_code_out, 4'h9);
    for (int d = 0; d < 4; d++) begin
      r = xs();
      period(d[3:0], r[2:0]);
    end
    period(4'h9, 3'h0);
    dither(3'h3, 5'h01);
    dither(3'h3, 5'h1f);
    dither(3'h7, 5'h05);
    dither(3'h7, 5'h00);
    dither(3'h0, 5'h00);
    repeat (3) begin
      r = xs();
      dither(r[2:0], r[8:4]);
    end
    bus_write(ADDR_CTRL, 32'h0000_0001);
    read_check(ADDR_CTRL, 32'h0000_0000);
    @(posedge clk_in);
    internal_clk_stable_in <= 1'b1;
    bus_write(ADDR_CTRL, 32'h0000_0001);
    read_check(ADDR_CTRL, 32'h0000_0005);
    @(posedge clk_in);
    internal_clk_stable_in <= 1'b0;
    fault_pulse();
    check_val(monitor_fault_flag_out, 1'b1);
    read_check(ADDR_CTRL, 32'h0000_0003);
    bus_write(ADDR_CTRL, 32'h0000_0003);
    bus_write(ADDR_CTRL, 32'h0000_0001);
    read_check(ADDR_CTRL, 32'h0000_0003);
    bus_write(ADDR_CTRL, 32'h0000_0001);
    @(negedge clk_in);
    check_val(monitor_fault_flag_out, 1'b0);
    bus_write(ADDR_CTRL, 32'h0000_0000);
    fault_pulse();
    check_val(monitor_fault_flag_out, 1'b0);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      n = (i == 0) ? 7'h7f : r[6:0];
      bus_write(ADDR_MULT, {25'h000_0000, n});
      repeat (2) @(negedge clk_in);
      check_val(multiply_factor_out, {25'h000_0000, n});
      check_val(freq_target_out, {25'h000_0000, n} * 32'h0004_b000);
      read_check(ADDR_TARGET, {25'h000_0000, n} * 32'h0004_b000);
    end
    @(posedge clk_in);
    internal_clk_stable_in <= 1'b1;
    bus_write(ADDR_CTRL, 32'h0000_0001);
    @(negedge clk_in);
    check_val(monitor_enable_out, 1'b1);
    read_check(4'h2, 32'h0000_0000);
    bus_write(4'h6, 32'hffff_ffff);
    read_check(ADDR_MULT, {25'h000_0000, n});
    report_and_stop();
  end

endmodule : dco_period_control_tb_top
